// ### include/pia_pkg.sv
// Constants and types shared by the priority interrupt arbiter
package pia_pkg;
  // ==========================================================
  // Sizes
  localparam int NSRC   = 82;
  localparam int IDX_W  = 7;
  localparam int LVL_W  = 2;
  localparam int NLVL   = 4;
  localparam int VBA_W  = 14;
  localparam int ADDR_W = 21;
  localparam int FVL_W  = 16;
  localparam int FVH_W  = ADDR_W - FVL_W;
  // ==========================================================
  // Source layout
  // Sources whose level cannot be programmed, and their level
  localparam logic [NSRC-1:0]  FIXED_MASK = 82'h3;
  localparam logic [LVL_W-1:0] FIXED_LVL  = 2'h3;
  // Slot of external request A in the source list
  localparam logic [IDX_W-1:0] EXT_A_IDX  = 7'h02;
  // Level that qualifies a match as fast
  localparam logic [LVL_W-1:0] FAST_LVL   = 2'h2;
  // ==========================================================
  // Current level codes
  localparam logic [1:0] LC_NONE = 2'h0;
  localparam logic [1:0] LC_P0   = 2'h1;
  localparam logic [1:0] LC_P1   = 2'h2;
  localparam logic [1:0] LC_P23  = 2'h3;
  // ==========================================================
  // Reset fetch
  localparam logic [ADDR_W-1:0] RESET_ADDR = 21'h000000;
  localparam int CLK_NS   = 8;
  localparam int BOOT_NS  = 16;
  localparam int BOOT_CYC = (BOOT_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] BOOT_LAST = 4'(BOOT_CYC - 1);
  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    ST_BOOT = 2'h0,
    ST_RUN  = 2'h1
  } pia_state_t;
endpackage

// ### logic/pia_encoder.sv
// Lowest-number-wins encoder for one priority level
`timescale 1ns/10ps
module pia_encoder #(
  parameter int N = 82,
  parameter int W = 7
) (
  input  wire logic [N-1:0] req,
  output logic              valid,
  output logic [W-1:0]      idx
);
  // ==========================================================
  // Scan downward so the lowest active number is kept last
  always_comb begin
    valid = 1'b0;
    idx   = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        valid = 1'b1;
        idx   = W'(i);
      end
    end
  end
endmodule // pia_encoder

// ### logic/pia_arbiter.sv
// Priority interrupt arbiter: level select, vector build, wake, reset fetch
// Functional notes
// - Eighty-two sources each get one of four levels, programmable except fixed ones.
// - Within one level the lowest active source number wins, source 0 first.
// - A normal vector is the vector base joined with the winning source number.
// - The core sees a pending flag and the address to jump to.
// - All configuration comes in and all status goes out on plain ports.
// - Core mask 00 allows all levels, 01 blocks 0, 10 blocks 0-1, 11 allows only 3.
// - Level code is 00 none, 01 level 0, 10 level 1, 11 level 2 or 3.
// - A new request is raised only at or above the level set by the core mask.
// - Two fast channels are programmed independently of vectored handling.
// - A pending request in wait or stop mode raises a wake to the system unit.
// - After reset the initial fetch address is driven onto the address bus.
// - A level-2 winner matching a fast register takes that channel's address.
// - In low power only sources enabled before entry wake, and request A is level low.
`timescale 1ns/10ps
module pia_arbiter (
  input  wire logic                              SYS_CLK,
  input  wire logic                              ARST_N,
  input  wire logic [pia_pkg::NSRC-1:0]          IRQ_REQ,
  input  wire logic [pia_pkg::NSRC-1:0]          IRQ_ENABLE,
  input  wire logic [2*pia_pkg::NSRC-1:0]        IRQ_PRIO,
  input  wire logic [1:0]                        CORE_MASK,
  input  wire logic [pia_pkg::VBA_W-1:0]         VECTOR_BASE,
  input  wire logic [pia_pkg::IDX_W-1:0]         FAST_MATCH_ZERO,
  input  wire logic [pia_pkg::IDX_W-1:0]         FAST_MATCH_ONE,
  input  wire logic [pia_pkg::FVL_W-1:0]         FAST_VECTOR_LOW0,
  input  wire logic [pia_pkg::FVH_W-1:0]         FAST_VECTOR_HIGH0,
  input  wire logic [pia_pkg::FVL_W-1:0]         FAST_VECTOR_LOW1,
  input  wire logic [pia_pkg::FVH_W-1:0]         FAST_VECTOR_HIGH1,
  input  wire logic                              EXT_REQ_A_N,
  input  wire logic                              EXT_A_EDGE,
  input  wire logic                              LOW_POWER,
  input  wire logic                              IRQ_ACK,
  output logic                                   IRQ_PENDING,
  output logic [pia_pkg::ADDR_W-1:0]             VECTOR_ADDR,
  output logic [1:0]                             CURRENT_LEVEL_CODE,
  output logic [1:0]                             FAST_SELECT,
  output logic                                   WAKE_REQ,
  output logic [pia_pkg::ADDR_W-1:0]             ADDR_BUS,
  output logic                                   ADDR_DRIVE
);
  // ==========================================================
  // Declarations
  logic                       a_s1_r, a_s2_r, a_s3_r;
  logic                       ext_lat_r, ext_lat_nxt, ext_req;
  logic [pia_pkg::NSRC-1:0]   snap_en_r, snap_en_nxt, req_act;
  logic [pia_pkg::NSRC-1:0]   lvl_req [pia_pkg::NLVL];
  logic [pia_pkg::NLVL-1:0]   lvl_valid;
  logic [pia_pkg::IDX_W-1:0]  lvl_idx [pia_pkg::NLVL];
  logic                       sel_valid;
  logic [1:0]                 sel_lvl;
  logic [pia_pkg::IDX_W-1:0]  sel_idx;
  logic [1:0]                 fsel;
  logic [1:0]                 src_lvl;
  logic                       pend_r, pend_nxt, wake_r, wake_nxt, drv_r, drv_nxt;
  logic [1:0]                 lc_r, lc_nxt, fs_r;
  logic [pia_pkg::IDX_W-1:0]  idx_r;
  logic [pia_pkg::ADDR_W-1:0] vec_r, vec_nxt, bus_r, bus_nxt;
  logic [3:0]                 cnt_r, cnt_nxt;
  pia_pkg::pia_state_t        st_r, st_nxt;

  // ==========================================================
  // External request A: pin is asynchronous, two flops before use
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      a_s1_r <= 1'b1;
      a_s2_r <= 1'b1;
      a_s3_r <= 1'b1;
    end else begin
      a_s1_r <= EXT_REQ_A_N;
      a_s2_r <= a_s1_r;
      a_s3_r <= a_s2_r;
    end
  end

  // Edge latch; a fresh falling edge beats a same-cycle acknowledge
  always_comb begin
    ext_lat_nxt = (a_s3_r & ~a_s2_r)
                | (ext_lat_r & ~(IRQ_ACK & pend_r & (idx_r == pia_pkg::EXT_A_IDX)));
    // No clock to see an edge in low power, so the level is used
    ext_req = (EXT_A_EDGE & ~LOW_POWER) ? ext_lat_r : ~a_s2_r;
  end

  // ==========================================================
  // Enable snapshot: frozen while in low power
  always_comb begin
    snap_en_nxt = LOW_POWER ? snap_en_r : IRQ_ENABLE;
    req_act     = IRQ_REQ;
    req_act[pia_pkg::EXT_A_IDX] = ext_req;
    req_act     = req_act & (LOW_POWER ? snap_en_r : IRQ_ENABLE);
  end

  // Sort active requests by level; fixed sources ignore software
  always_comb begin
    for (int l = 0; l < pia_pkg::NLVL; l++) begin
      lvl_req[l] = '0;
    end
    src_lvl = '0;
    for (int i = 0; i < pia_pkg::NSRC; i++) begin
      src_lvl = pia_pkg::FIXED_MASK[i] ? pia_pkg::FIXED_LVL : IRQ_PRIO[2*i +: 2];
      lvl_req[src_lvl][i] = req_act[i];
    end
  end

  // One encoder per level
  for (genvar g = 0; g < pia_pkg::NLVL; g++) begin : g_enc
    pia_encoder #(
      .N (pia_pkg::NSRC),
      .W (pia_pkg::IDX_W)
    ) u_enc (
      .req   (lvl_req[g]),
      .valid (lvl_valid[g]),
      .idx   (lvl_idx[g])
    );
  end

  // ==========================================================
  // Highest unmasked level wins; ascending scan keeps the top one
  always_comb begin
    sel_valid = 1'b0;
    sel_lvl   = '0;
    sel_idx   = '0;
    for (int l = 0; l < pia_pkg::NLVL; l++) begin
      if (lvl_valid[l] && (2'(l) >= CORE_MASK)) begin
        sel_valid = 1'b1;
        sel_lvl   = 2'(l);
        sel_idx   = lvl_idx[l];
      end
    end
  end

  // Vector build: match zero checked before match one
  always_comb begin
    fsel = 2'h0;
    if (sel_lvl == pia_pkg::FAST_LVL) begin
      if (sel_idx == FAST_MATCH_ZERO) begin
        fsel = 2'h1;
      end else if (sel_idx == FAST_MATCH_ONE) begin
        fsel = 2'h2;
      end
    end
    if (fsel[0]) begin
      vec_nxt = {FAST_VECTOR_HIGH0, FAST_VECTOR_LOW0};
    end else if (fsel[1]) begin
      vec_nxt = {FAST_VECTOR_HIGH1, FAST_VECTOR_LOW1};
    end else begin
      vec_nxt = {VECTOR_BASE, sel_idx};
    end
    pend_nxt = sel_valid;
    wake_nxt = LOW_POWER & (|req_act);
    case (sel_lvl)
      2'h0:    lc_nxt = pia_pkg::LC_P0;
      2'h1:    lc_nxt = pia_pkg::LC_P1;
      default: lc_nxt = pia_pkg::LC_P23;
    endcase
    if (!sel_valid) begin
      lc_nxt = pia_pkg::LC_NONE;
    end
  end

  // ==========================================================
  // Reset fetch: hold the initial address for a short window
  always_comb begin
    st_nxt  = st_r;
    cnt_nxt = cnt_r;
    case (st_r)
      pia_pkg::ST_BOOT: begin
        if (cnt_r == pia_pkg::BOOT_LAST) begin
          st_nxt = pia_pkg::ST_RUN;
        end else begin
          cnt_nxt = cnt_r + 4'h1;
        end
      end
      pia_pkg::ST_RUN: begin
        st_nxt = pia_pkg::ST_RUN;
      end
      default: begin
        st_nxt = pia_pkg::ST_BOOT;
      end
    endcase
    drv_nxt = (st_nxt == pia_pkg::ST_BOOT);
    bus_nxt = drv_nxt ? pia_pkg::RESET_ADDR : vec_nxt;
  end

  // All state except the request A synchronizer flops registered here
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ext_lat_r <= 1'b0;
      snap_en_r <= '0;
      pend_r    <= 1'b0;
      wake_r    <= 1'b0;
      lc_r      <= pia_pkg::LC_NONE;
      fs_r      <= 2'h0;
      idx_r     <= '0;
      vec_r     <= '0;
      st_r      <= pia_pkg::ST_BOOT;
      cnt_r     <= 4'h0;
      drv_r     <= 1'b1;
      bus_r     <= pia_pkg::RESET_ADDR;
    end else begin
      ext_lat_r <= ext_lat_nxt;
      snap_en_r <= snap_en_nxt;
      pend_r    <= pend_nxt;
      wake_r    <= wake_nxt;
      lc_r      <= lc_nxt;
      fs_r      <= fsel;
      idx_r     <= sel_idx;
      vec_r     <= vec_nxt;
      st_r      <= st_nxt;
      cnt_r     <= cnt_nxt;
      drv_r     <= drv_nxt;
      bus_r     <= bus_nxt;
    end
  end

  assign IRQ_PENDING        = pend_r;
  assign VECTOR_ADDR        = vec_r;
  assign CURRENT_LEVEL_CODE = lc_r;
  assign FAST_SELECT        = fs_r;
  assign WAKE_REQ           = wake_r;
  assign ADDR_BUS           = bus_r;
  assign ADDR_DRIVE         = drv_r;

  // ==========================================================
  // Checks
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!ARST_N);

  logic no_lower;
  assign no_lower = ~|(lvl_req[sel_lvl] & ((82'h1 << sel_idx) - 82'h1));

  mask_gate_a: assert property (pend_r |-> $past(sel_lvl) >= $past(CORE_MASK))
    else $error("Pending level is masked");
  lowest_win_a: assert property (pend_r |-> $past(no_lower))
    else $error("A lower source number was skipped");
  vec_cat_a: assert property (pend_r && fs_r == 2'h0
                              |-> vec_r == {$past(VECTOR_BASE), idx_r})
    else $error("Normal vector is not base joined with number");
  fast_zero_a: assert property (fs_r[0] |-> lc_r == pia_pkg::LC_P23
                                && vec_r == {$past(FAST_VECTOR_HIGH0), $past(FAST_VECTOR_LOW0)})
    else $error("Fast channel zero address wrong");
  // Pending and a non-zero level code always travel together
  level_code_a: assert property (pend_r == (lc_r != pia_pkg::LC_NONE))
    else $error("Level code disagrees with pending");
  top_level_a: assert property (sel_valid && lvl_valid[3] && CORE_MASK != 2'h0
                                |=> lc_r == pia_pkg::LC_P23)
    else $error("Top level not chosen");
  wake_mode_a: assert property (WAKE_REQ |-> $past(LOW_POWER))
    else $error("Wake outside low power");
  snap_hold_a: assert property (LOW_POWER && $past(LOW_POWER) |-> $stable(snap_en_r))
    else $error("Enable snapshot moved in low power");
  boot_fetch_a: assert property (drv_r |-> ADDR_BUS == pia_pkg::RESET_ADDR)
    else $error("Reset fetch address not driven");
  ext_hold_a: assert property (a_s3_r && !a_s2_r |=> ext_lat_r)
    else $error("Edge on request A lost");

  pend_c: cover property (pend_r && fs_r == 2'h0);
  fast_c: cover property (fs_r[1]);
  wake_c: cover property (WAKE_REQ);
  nest_c: cover property (pend_r && CORE_MASK == 2'h3);
endmodule // pia_arbiter

// ### sim/pia_core_model.sv
// Core-side model that sees the pending flag and acknowledges it
`timescale 1ns/10ps
module pia_core_model (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic pending,
  input  wire logic ack_en,
  output logic      ack
);
  // ==========================================================
  // Acknowledge
  // One-cycle pulse, never two in a row, driven just after the edge
  // Acts 2 ns after the edge so the bench's 1 ns enable is already settled
  initial begin
    ack = 1'b0;
    forever begin
      @(posedge clk);
      #2;
      ack = ack_en && rst_n && (pending === 1'b1) && !ack;
    end
  end
endmodule // pia_core_model

// ### sim/pia_arbiter_tb.sv
// Self-checking bench for the priority interrupt arbiter
`timescale 1ns/10ps
module pia_arbiter_tb;
  logic         clk, arst_n, ext_a_n, ext_edge, low_power, irq_ack, ack_en;
  logic [81:0]  irq_req, irq_en;
  logic [163:0] irq_prio;
  logic [1:0]   core_mask, lvl_code, fsel;
  logic [13:0]  vb;
  logic [6:0]   fm0, fm1;
  logic [15:0]  fvl0, fvl1;
  logic [4:0]   fvh0, fvh1;
  logic         pend, wake, adrv;
  logic [20:0]  vaddr, abus;
  int           error_cnt, compares;

  pia_arbiter pia_arbiter_inst (.SYS_CLK(clk), .ARST_N(arst_n), .IRQ_REQ(irq_req),
    .IRQ_ENABLE(irq_en), .IRQ_PRIO(irq_prio), .CORE_MASK(core_mask), .VECTOR_BASE(vb),
    .FAST_MATCH_ZERO(fm0), .FAST_MATCH_ONE(fm1), .FAST_VECTOR_LOW0(fvl0),
    .FAST_VECTOR_HIGH0(fvh0), .FAST_VECTOR_LOW1(fvl1), .FAST_VECTOR_HIGH1(fvh1),
    .EXT_REQ_A_N(ext_a_n), .EXT_A_EDGE(ext_edge), .LOW_POWER(low_power),
    .IRQ_ACK(irq_ack), .IRQ_PENDING(pend), .VECTOR_ADDR(vaddr),
    .CURRENT_LEVEL_CODE(lvl_code), .FAST_SELECT(fsel), .WAKE_REQ(wake),
    .ADDR_BUS(abus), .ADDR_DRIVE(adrv));
  pia_core_model pia_core_model_inst (.clk(clk), .rst_n(arst_n), .pending(pend),
    .ack_en(ack_en), .ack(irq_ack));

  // ==========================================================
  // Helpers
  task automatic print_verdict();
    if (error_cnt == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Inputs move 1 ns after the edge so sampling never races
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Bounded wait on the pending flag; a hang ends the run
  task automatic wait_pend(input logic want);
    for (int k = 0; k < 10; k++) begin
      if (pend === want) return;
      step(1);
    end
    chk(pend, want);
    print_verdict();
  endtask
  task automatic clr();
    irq_req = '0; irq_en = '0; irq_prio = '0; core_mask = 2'h0; low_power = 1'b0;
  endtask
  task automatic src(input int i, input int l);
    irq_req[i] = 1'b1; irq_en[i] = 1'b1; irq_prio[2*i+:2] = 2'(l);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_order();
    clr(); src(9, 1); src(5, 1); step(1);
    chk(pend, 1);
    chk(vaddr, {vb, 7'h05});
    chk(abus, {vb, 7'h05});
    chk(lvl_code, 2'h2);
    src(70, 2); src(81, 3); step(1);
    chk(vaddr, {vb, 7'h51});
    chk(lvl_code, 2'h3);
  endtask
  // Every mask against every level, one source
  task automatic t_mask();
    for (int m = 0; m < 4; m++) for (int l = 0; l < 4; l++) begin
      clr(); src(20, l); core_mask = 2'(m); step(1);
      chk(pend, l >= m);
      chk(lvl_code, (l < m) ? 0 : (l == 0) ? 1 : (l == 1) ? 2 : 3);
    end
  endtask
  // Source 0 programmed low still passes the tightest mask
  task automatic t_fixed();
    clr(); src(0, 0); src(3, 3); core_mask = 2'h3; step(1);
    chk(vaddr, {vb, 7'h00});
  endtask
  task automatic t_fast();
    clr(); fm1 = 7'h2c; src(44, 2); step(1);
    chk(vaddr, {fvh1, fvl1});
    chk(fsel, 2'h2);
    fm0 = 7'h2c; step(1);
    chk(vaddr, {fvh0, fvl0});
    chk(fsel, 2'h1);
    irq_prio[89:88] = 2'h1; step(1);
    chk(vaddr, {vb, 7'h2c});
  endtask
  // Enables must stand one edge before low power, or the snapshot misses them
  task automatic t_wake();
    clr(); src(5, 1); step(1);
    low_power = 1'b1; step(1);
    chk(wake, 1);
    irq_req = '0; irq_en = '0; src(9, 1); step(2);
    chk(wake, 0);
    clr(); ext_edge = 1'b1; irq_en[2] = 1'b1; step(1);
    low_power = 1'b1; ext_a_n = 1'b0; step(4);
    chk(wake, 1);
    ext_a_n = 1'b1; step(4);
    chk(wake, 0);
  endtask
  // Short edge on request A is held until the core takes it
  // The low-power pulse left an edge latched; the core drains it first
  task automatic t_edge();
    clr(); ext_edge = 1'b1; src(2, 1); ack_en = 1'b1; step(4);
    ack_en = 1'b0;
    chk(pend, 0);
    ext_a_n = 1'b0; step(2);
    ext_a_n = 1'b1; wait_pend(1'b1);
    chk(vaddr, {vb, 7'h02});
    ack_en = 1'b1; wait_pend(1'b0);
    ack_en = 1'b0; step(2);
    chk(pend, 0);
  endtask

  // ==========================================================
  // Clock and main sequence
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    error_cnt = 0; compares = 0; arst_n = 1'b0; ext_a_n = 1'b1; ext_edge = 1'b0;
    ack_en = 1'b0; vb = 14'h2a5c; fm0 = 7'h7f; fm1 = 7'h7f;
    fvl0 = 16'h1234; fvh0 = 5'h0a; fvl1 = 16'hbeef; fvh1 = 5'h15; clr();
    step(12);
    chk(adrv, 1);
    chk(abus, 21'h0);
    arst_n = 1'b1; step(1);
    chk(adrv, 1);
    step(1);
    chk(adrv, 0);
    t_order(); t_mask(); t_fixed(); t_fast(); t_wake(); t_edge();
    print_verdict();
  end
endmodule // pia_arbiter_tb
